// ---- include/sdm_consts.svh ----
// Constants of the servo deviation error monitor: offsets, fields, reset values, timing
`ifndef SDM_CONSTS_SVH
`define SDM_CONSTS_SVH
// Register byte offsets
`define SDM_OFS_SELECT     12'h000
`define SDM_OFS_POS_LEVEL  12'h004
`define SDM_OFS_SPD_LEVEL  12'h008
`define SDM_OFS_THR_LEVEL  12'h00C
`define SDM_OFS_ALARM      12'h010
`define SDM_OFS_IRQ_STATUS 12'h014
`define SDM_OFS_IRQ_MASK   12'h018
`define SDM_OFS_STATE      12'h01C
// Field widths
`define SDM_SEL_W   3
`define SDM_POS_W   10
`define SDM_SPD_W   13
`define SDM_THR_W   10
`define SDM_IRQ_W   4
`define SDM_VAL_W   32
`define SDM_DIV_W   16
// Check select bits
`define SDM_SEL_POS 0
`define SDM_SEL_SPD 1
`define SDM_SEL_THR 2
// Event bits (alarm bits share 0..2)
`define SDM_EV_POLE 3
// State register bits
`define SDM_ST_SERVO_ON 0
`define SDM_ST_POLE_DONE 1
`define SDM_ST_POLE_BUSY 2
`define SDM_ST_STOP 3
// Reset values
`define SDM_SEL_RST 3'h3
`define SDM_POS_RST 10'h032
`define SDM_SPD_RST 13'h03E8
`define SDM_THR_RST 10'h064
// Accepted ranges of the levels
`define SDM_POS_MIN 10'h001
`define SDM_POS_MAX 10'h3E8
`define SDM_SPD_MIN 13'h0001
`define SDM_SPD_MAX 13'h1388
`define SDM_THR_MIN 10'h001
`define SDM_THR_MAX 10'h3E8
// Control cycle timing
`define SDM_CTRL_PERIOD_NS 1000
`define SDM_MCLK_PERIOD_NS 25
`endif

// ---- include/sdm_pkg.sv ----
// Types of the servo deviation error monitor
`include "sdm_consts.svh"
package sdm_pkg;
	// Model and feedback quantities, signed, one control cycle's worth
	typedef struct packed {
		logic signed [`SDM_VAL_W-1:0] modelPos;
		logic signed [`SDM_VAL_W-1:0] fbPos;
		logic signed [`SDM_VAL_W-1:0] modelSpd;
		logic signed [`SDM_VAL_W-1:0] fbSpd;
		logic signed [`SDM_VAL_W-1:0] cmdThr;
		logic signed [`SDM_VAL_W-1:0] fbThr;
	} sdm_sample_t;

	typedef enum logic [2:0] {
		SDM_OFF  = 3'h1,
		SDM_POLE = 3'h2,
		SDM_ON   = 3'h4
	} sdm_servo_t;

	// Whole state of the monitor
	typedef struct packed {
		logic [`SDM_SEL_W-1:0] sel;
		logic [`SDM_POS_W-1:0] posLvl;
		logic [`SDM_SPD_W-1:0] spdLvl;
		logic [`SDM_THR_W-1:0] thrLvl;
		logic [2:0]            alarm;
		logic [`SDM_IRQ_W-1:0] irqSt;
		logic [`SDM_IRQ_W-1:0] irqMask;
		sdm_servo_t            servo;
		logic                  poleDone;
		logic [`SDM_DIV_W-1:0] divCnt;
		logic                  tick;
		logic [2:0]            syncOn;
		logic [2:0]            syncInc;
		logic                  onReq;
		logic                  incEnc;
		logic [31:0]           prdata;
		logic                  pready;
		logic                  pslverr;
		logic                  irq;
		logic                  stop;
		logic                  servoOnStat;
		logic                  poleDetect;
	} sdm_state_t;
endpackage : sdm_pkg

// ---- hdl/sdm_abs_diff.sv ----
// Magnitude of the difference of two signed values
`timescale 1ns/1ps
`default_nettype none
module sdm_abs_diff #(
	parameter int W = 32
) (
	input  wire logic signed [W-1:0] a,
	input  wire logic signed [W-1:0] b,
	output logic             [W:0]   mag
);
	logic signed [W:0] diff;

	// One bit wider so that the extremes cannot overflow
	always_comb begin
		diff = $signed({a[W-1], a}) - $signed({b[W-1], b});
		mag  = diff[W] ? (W+1)'(-diff) : (W+1)'(diff);
	end
endmodule : sdm_abs_diff
`default_nettype wire

// ---- hdl/sdm_monitor.sv ----
// Servo deviation error monitor with pole detection sequencing and APB registers
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sdm_monitor
	import sdm_pkg::*;
#(
	parameter int CTRL_DIV = `SDM_CTRL_PERIOD_NS / `SDM_MCLK_PERIOD_NS
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Servo quantities from the control loop and the encoder
	input  wire sdm_sample_t sample,
	// Pins from the motion controller and the encoder
	input  wire logic        servoOnReq,
	input  wire logic        incrementalEnc,
	// Pole detection handshake with the drive logic
	input  wire logic        poleDetDone,
	output logic             poleDetect,
	// Status toward the controller and the power stage
	output logic             servoOnStatus,
	output logic             motorStop,
	output logic             irq
);
	sdm_state_t q;
	sdm_state_t d;

	// Divider counter must hold the control period; refused while elaborating, before any cycle runs
	if (CTRL_DIV < 1 || CTRL_DIV > (1 << `SDM_DIV_W)) begin : gDivCheck
		$error("CTRL_DIV out of range");
	end

	// Last count of the divider; the tick fires when the counter reaches it
	localparam logic [`SDM_DIV_W-1:0] DIV_LAST = `SDM_DIV_W'(CTRL_DIV - 1);

	logic [`SDM_VAL_W:0] posMag;
	logic [`SDM_VAL_W:0] spdMag;
	logic [`SDM_VAL_W:0] thrMag;

	// Deviation magnitudes, one instance per quantity
	sdm_abs_diff #(.W(`SDM_VAL_W)) uPos (
		.a   (sample.modelPos),
		.b   (sample.fbPos),
		.mag (posMag)
	);
	sdm_abs_diff #(.W(`SDM_VAL_W)) uSpd (
		.a   (sample.modelSpd),
		.b   (sample.fbSpd),
		.mag (spdMag)
	);
	sdm_abs_diff #(.W(`SDM_VAL_W)) uThr (
		.a   (sample.cmdThr),
		.b   (sample.fbThr),
		.mag (thrMag)
	);

	logic        setup;
	logic        wrDone;
	logic        rdDone;
	logic [2:0]  alarmHit;
	logic [2:0]  alarmNew;
	logic [3:0]  events;
	logic        checking;
	logic [31:0] rdVal;
	logic        rdErr;
	logic        wrErr;
	logic [2:0]  alarmClr;

	always_comb begin
		d = q;
		setup  = psel & ~penable;
		wrDone = psel & penable & q.pready & pwrite;
		rdDone = psel & penable & q.pready & ~pwrite;

		// Control cycle enable: checks run once per control period
		if (q.divCnt == DIV_LAST) begin
			d.divCnt = '0;
			d.tick   = 1'b1;
		end else begin
			d.divCnt = q.divCnt + `SDM_DIV_W'(1);
			d.tick   = 1'b0;
		end

		// Pin filters: first flop only feeds the second
		d.syncOn  = {q.syncOn[1:0], servoOnReq};
		d.syncInc = {q.syncInc[1:0], incrementalEnc};
		if (q.syncOn[1] == q.syncOn[2]) begin
			d.onReq = q.syncOn[2];
		end
		if (q.syncInc[1] == q.syncInc[2]) begin
			d.incEnc = q.syncInc[2];
		end

		// Checks only look while the servo is engaged; the loop is idle otherwise
		checking = q.tick & (q.servo != SDM_OFF);
		alarmHit[`SDM_SEL_POS] = checking & q.sel[`SDM_SEL_POS]
			& (posMag >= (`SDM_VAL_W+1)'(q.posLvl));
		alarmHit[`SDM_SEL_SPD] = checking & q.sel[`SDM_SEL_SPD]
			& (spdMag > (`SDM_VAL_W+1)'(q.spdLvl));
		alarmHit[`SDM_SEL_THR] = checking & q.sel[`SDM_SEL_THR]
			& (thrMag > (`SDM_VAL_W+1)'(q.thrLvl));
		alarmNew = alarmHit & ~q.alarm;

		// Register writes; out-of-range levels are refused and the old value kept
		// Decoded through the whole transfer so that the refusal is known in setup
		wrErr    = 1'b0;
		alarmClr = '0;
		if (psel & pwrite) begin
			case (paddr)
				`SDM_OFS_SELECT: begin
					d.sel = pwdata[`SDM_SEL_W-1:0];
				end
				`SDM_OFS_POS_LEVEL: begin
					if (pwdata >= 32'(`SDM_POS_MIN) && pwdata <= 32'(`SDM_POS_MAX)) begin
						d.posLvl = pwdata[`SDM_POS_W-1:0];
					end else begin
						wrErr = 1'b1;
					end
				end
				`SDM_OFS_SPD_LEVEL: begin
					if (pwdata >= 32'(`SDM_SPD_MIN) && pwdata <= 32'(`SDM_SPD_MAX)) begin
						d.spdLvl = pwdata[`SDM_SPD_W-1:0];
					end else begin
						wrErr = 1'b1;
					end
				end
				`SDM_OFS_THR_LEVEL: begin
					if (pwdata >= 32'(`SDM_THR_MIN) && pwdata <= 32'(`SDM_THR_MAX)) begin
						d.thrLvl = pwdata[`SDM_THR_W-1:0];
					end else begin
						wrErr = 1'b1;
					end
				end
				`SDM_OFS_ALARM: begin
					alarmClr = pwdata[2:0];
				end
				`SDM_OFS_IRQ_MASK: begin
					d.irqMask = pwdata[`SDM_IRQ_W-1:0];
				end
				`SDM_OFS_IRQ_STATUS, `SDM_OFS_STATE: begin
					wrErr = 1'b0;
				end
				default: begin
					wrErr = 1'b1;
				end
			endcase
		end
		// Only the edge that samples pready high commits a write; every other cycle keeps the old fields
		// Decoding early costs a few muxes but keeps pslverr valid together with pready
		if (!wrDone) begin
			d.sel     = q.sel;
			d.posLvl  = q.posLvl;
			d.spdLvl  = q.spdLvl;
			d.thrLvl  = q.thrLvl;
			d.irqMask = q.irqMask;
			alarmClr  = '0;
		end

		// Latched alarms: a fresh hit wins over a clear in the same cycle
		d.alarm = (q.alarm & ~alarmClr) | alarmHit;
		d.stop  = |d.alarm;

		// Servo sequencing; pole detection once per power-on with an incremental encoder
		d.poleDetect = 1'b0;
		case (q.servo)
			SDM_OFF: begin
				if (q.onReq && !q.stop) begin
					if (q.incEnc && !q.poleDone) begin
						d.servo = SDM_POLE;
						d.poleDetect = 1'b1;
					end else begin
						d.servo = SDM_ON;
					end
				end
			end
			SDM_POLE: begin
				d.poleDetect = 1'b1;
				if (!q.onReq || q.stop) begin
					d.servo = SDM_OFF;
					d.poleDetect = 1'b0;
				end else if (poleDetDone) begin
					d.servo = SDM_ON;
					d.poleDone = 1'b1;
					d.poleDetect = 1'b0;
				end
			end
			SDM_ON: begin
				if (!q.onReq || q.stop) begin
					d.servo = SDM_OFF;
				end
			end
			default: begin
				d.servo = SDM_OFF;
			end
		endcase
		if (|alarmHit) begin
			d.servo = SDM_OFF;
			d.poleDetect = 1'b0;
		end
		// Status only after detection finished: the controller's interlock relies on it
		d.servoOnStat = (d.servo == SDM_ON);

		// Interrupt status: a read clears only the bits it returned, so later events survive
		// Bit 3 marks the end of pole detection, bits 0..2 a fresh alarm
		events = {(q.servo == SDM_POLE) & (d.servo == SDM_ON), alarmNew};
		if (rdDone && paddr == `SDM_OFS_IRQ_STATUS) begin
			d.irqSt = (q.irqSt & ~q.prdata[`SDM_IRQ_W-1:0]) | events;
		end else begin
			d.irqSt = q.irqSt | events;
		end
		d.irq = |(d.irqSt & d.irqMask);

		// Read data is captured in setup so the access phase completes at once
		rdVal = '0;
		rdErr = 1'b0;
		case (paddr)
			`SDM_OFS_SELECT:     rdVal = 32'(q.sel);
			`SDM_OFS_POS_LEVEL:  rdVal = 32'(q.posLvl);
			`SDM_OFS_SPD_LEVEL:  rdVal = 32'(q.spdLvl);
			`SDM_OFS_THR_LEVEL:  rdVal = 32'(q.thrLvl);
			`SDM_OFS_ALARM:      rdVal = 32'(q.alarm);
			`SDM_OFS_IRQ_STATUS: rdVal = 32'(q.irqSt);
			`SDM_OFS_IRQ_MASK:   rdVal = 32'(q.irqMask);
			`SDM_OFS_STATE: begin
				rdVal[`SDM_ST_SERVO_ON]  = q.servoOnStat;
				rdVal[`SDM_ST_POLE_DONE] = q.poleDone;
				rdVal[`SDM_ST_POLE_BUSY] = q.poleDetect;
				rdVal[`SDM_ST_STOP]      = q.stop;
			end
			default: rdErr = 1'b1;
		endcase
		// Zero wait states: pready answers every setup cycle at the next edge
		d.pready = setup;
		// Response stands until the next setup; write refusal travels with pready
		if (setup) begin
			d.prdata  = pwrite ? 32'h0000_0000 : rdVal;
			d.pslverr = pwrite ? wrErr : rdErr;
		end
	end

	// Single state register; reset values are constants only
	always_ff @(posedge mclk) begin
		if (rst) begin
			q.sel         <= `SDM_SEL_RST;
			q.posLvl      <= `SDM_POS_RST;
			q.spdLvl      <= `SDM_SPD_RST;
			q.thrLvl      <= `SDM_THR_RST;
			q.alarm       <= '0;
			q.irqSt       <= '0;
			q.irqMask     <= '0;
			q.servo       <= SDM_OFF;
			q.poleDone    <= 1'b0;
			q.divCnt      <= '0;
			q.tick        <= 1'b0;
			q.syncOn      <= '0;
			q.syncInc     <= '0;
			q.onReq       <= 1'b0;
			q.incEnc      <= 1'b0;
			q.prdata      <= '0;
			q.pready      <= 1'b0;
			q.pslverr     <= 1'b0;
			q.irq         <= 1'b0;
			q.stop        <= 1'b0;
			q.servoOnStat <= 1'b0;
			q.poleDetect  <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state register
	assign prdata        = q.prdata;
	assign pready        = q.pready;
	assign pslverr       = q.pslverr;
	assign poleDetect    = q.poleDetect;
	assign servoOnStatus = q.servoOnStat;
	assign motorStop     = q.stop;
	assign irq           = q.irq;
endmodule : sdm_monitor
`default_nettype wire

// ---- verification/sdm_chk_monitor.sv ----
// Port assertions of the servo deviation monitor
`timescale 1ns/1ps
`default_nettype none
module sdm_chk #(
	parameter int CTRL_DIV = 40
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic servoOnReq,
	input wire logic poleDetDone,
	input wire logic poleDetect,
	input wire logic servoOnStatus,
	input wire logic motorStop,
	input wire logic irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// Clear may reach the stop pin a cycle after the write
	logic wrAcc;
	logic act;
	assign wrAcc = psel & penable & pwrite;
	assign act = servoOnStatus | poleDetect;
	property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
	a_rdy: assert property (p_rdy) else $error("pready width");
	property p_latch; motorStop && !wrAcc && !$past(wrAcc) |=> motorStop; endproperty
	a_latch: assert property (p_latch) else $error("stop released");
	property p_drop; $rose(motorStop) |-> ##[1:2] !servoOnStatus; endproperty
	a_drop: assert property (p_drop) else $error("servo kept on");
	property p_eng; $rose(motorStop) |-> act || $past(act); endproperty
	a_eng: assert property (p_eng) else $error("alarm while off");
	property p_onpole; $rose(servoOnStatus) |-> !poleDetect; endproperty
	a_onpole: assert property (p_onpole) else $error("on during pole");
	property p_poleend; poleDetect && poleDetDone |-> ##[1:2] !poleDetect; endproperty
	a_poleend: assert property (p_poleend) else $error("pole not ended");
	property p_irqfall; $fell(irq) |-> $past(psel) || $past(psel, 2); endproperty
	a_irqfall: assert property (p_irqfall) else $error("irq fell alone");
	property p_reqoff; !servoOnReq [*8] |-> !servoOnStatus; endproperty
	a_reqoff: assert property (p_reqoff) else $error("on without request");
	property p_block; $rose(servoOnStatus) |-> !motorStop; endproperty
	a_block: assert property (p_block) else $error("on with alarm");
	c_pole: cover property ($fell(poleDetect));
	c_stop: cover property ($rose(motorStop));
	c_irq: cover property ($rose(irq));
endmodule : sdm_chk
bind sdm_monitor sdm_chk #(.CTRL_DIV(CTRL_DIV)) u_chk (.*);
`default_nettype wire

// ---- verification/sdm_ctrl_model.sv ----
// Motion controller model: servo-on request, pole detection answer
`timescale 1ns/1ps
`default_nettype none
module sdm_ctrl_model (
	input  wire logic       mclk,
	input  wire logic       want,
	input  wire logic [7:0] poleWait,
	input  wire logic       poleDetect,
	input  wire logic       servoOnStatus,
	output logic            servoOnReq = 1'b0,
	output logic            poleDetDone = 1'b0,
	output logic            motionOk
);
	int cnt = 0;
	// Done pulses once, after a prompt or slow delay
	always @(posedge mclk) begin
		servoOnReq <= want;
		cnt <= poleDetect ? cnt + 1 : 0;
		poleDetDone <= poleDetect && cnt == poleWait;
	end
	// Motion is allowed only on confirmed servo-on
	assign motionOk = servoOnStatus & servoOnReq;
endmodule : sdm_ctrl_model
`default_nettype wire

// ---- verification/sdm_monitor_tb.sv ----
// Self-checking bench of the servo deviation monitor
`timescale 1ns/1ps
`default_nettype none
`include "sdm_consts.svh"
module sdm_monitor_tb import sdm_pkg::*; ;
	localparam int DIV = 2;
	logic        mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        incrementalEnc = 1'b1, want = 1'b0, err;
	logic        pready, pslverr, servoOnReq, poleDetDone, poleDetect, servoOnStatus, motorStop, irq, motionOk;
	logic [7:0]  poleWait = 8'h14;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	sdm_sample_t sample = '0;
	int          miscompares = 0, total_checks = 0, cyc = 0, s, k, d, ex;
	int          lvl[3] = '{50, 1000, 100};
	int          tv[9] = '{0, 1001, 1000, 0, 5001, 5000, 1001, 0, 1};
	always #12.5 mclk = ~mclk;
	sdm_monitor #(.CTRL_DIV(DIV)) dut (.*);
	sdm_ctrl_model ctl (.*);
	// Counted comparison; an unknown never matches
	task automatic chk(input string nm, input logic [31:0] exv, input logic [31:0] got);
		total_checks++;
		if (got !== exv) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exv, got);
		end
	endtask : chk
	// Request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dw);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= dw;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Level write; the model keeps the old value on refusal
	task automatic lv(input int i, input int v);
		logic ok;
		ok = v >= 1 && v <= (i == 1 ? 5000 : 1000);
		apb(1'b1, 12'(4 * i + 4), 32'(v));
		chk("refusal", {31'h0, !ok}, {31'h0, err});
		if (ok) lvl[i] = v;
		apb(1'b0, 12'(4 * i + 4), 32'h0);
		chk("level", lvl[i], rd);
	endtask : lv
	// Offsets one quantity; motion only on confirmed servo-on
	task automatic drive(input int i, input int e);
		sdm_sample_t v;
		v = {6{$urandom_range(0, 99999)}};
		if (i == 0) v.modelPos = v.fbPos + e;
		if (i == 1) v.modelSpd = v.fbSpd - e;
		if (i == 2) v.cmdThr = v.fbThr + e;
		@(posedge mclk);
		if (motionOk || e == 0) sample <= v;
	endtask : drive
	task automatic waitOn();
		repeat (300) if (!motionOk) @(posedge mclk);
		chk("servo on", 32'h1, {31'h0, motionOk});
	endtask : waitOn
	task automatic report_and_stop();
		if (miscompares == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop
	// Hang guard, well above the run length
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 60000) begin
			miscompares++;
			report_and_stop();
		end
	end
	initial begin
		void'($urandom(32'hCD56));
		tv[8] = $urandom_range(1, 1000);
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		for (k = 0; k < 4; k++) begin
			apb(1'b0, 12'(4 * k), 32'h0);
			chk("reset", k ? lvl[k - 1] : 3, rd);
		end
		for (k = 0; k < 9; k++) lv(k / 3, tv[k]);
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
		// Slow pole detection at first servo-on; its event stays masked
		want <= 1'b1;
		waitOn();
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'b0, `SDM_OFS_STATE, 32'h0);
		chk("state", 32'h3, rd);
		apb(1'b0, `SDM_OFS_IRQ_STATUS, 32'h0);
		chk("pole event", 32'h8, rd);
		apb(1'b1, `SDM_OFS_IRQ_MASK, 32'hF);
		// Every nonzero select value, each check just below and at its trip point
		for (s = 1; s < 8; s++) begin
			apb(1'b1, `SDM_OFS_SELECT, 32'(s));
			for (k = 0; k < 6; k++) begin
				d = k % 2;
				ex = (s[k / 2] && d) ? 1 << (k / 2) : 0;
				drive(k / 2, lvl[k / 2] - 1 + d + (k > 1));
				repeat (3 * DIV + 4) @(posedge mclk);
				chk("stop", ex != 0, motorStop);
				chk("irq", ex != 0, irq);
				drive(k / 2, 0);
				repeat (3 * DIV + 4) @(posedge mclk);
				apb(1'b0, `SDM_OFS_ALARM, 32'h0);
				chk("alarm", ex, rd);
				apb(1'b0, `SDM_OFS_IRQ_STATUS, 32'h0);
				chk("event", ex, rd);
				apb(1'b1, `SDM_OFS_ALARM, 32'h7);
				waitOn();
			end
		end
		// Power cycle: defaults return, pole detection repeats promptly
		rst <= 1'b1;
		want <= 1'b0;
		poleWait <= 8'h00;
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		apb(1'b0, `SDM_OFS_SELECT, 32'h0);
		chk("select", 32'h3, rd);
		want <= 1'b1;
		waitOn();
		apb(1'b0, `SDM_OFS_IRQ_STATUS, 32'h0);
		chk("pole again", 32'h8, rd);
		// Power cycle with an absolute encoder: servo comes on without pole detection
		rst <= 1'b1;
		want <= 1'b0;
		incrementalEnc <= 1'b0;
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		want <= 1'b1;
		waitOn();
		apb(1'b0, `SDM_OFS_STATE, 32'h0);
		chk("no pole", 32'h1, rd);
		report_and_stop();
	end
endmodule : sdm_monitor_tb
`default_nettype wire
